// file: sgwl_host_model.sv
// Host controller model driving the three-wire gain port
module sgwl_host_model (
    output logic serial_clk,     // Serial clock, also toggled outside frames by idle_clock
    output logic serial_gain_in, // Serial gain data
    output logic load_enable_n   // Load enable, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        serial_clk = 1'b0;
        serial_gain_in = 1'b0;
        load_enable_n = 1'b1;
    end
    task automatic load(input logic [7:0] word);
        load_enable_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            serial_gain_in = word[i];
            #160 serial_clk = 1'b1;
            #160 serial_clk = 1'b0;
        end
        #160 load_enable_n = 1'b1;
        serial_gain_in = ~word[0];
    endtask
    // Clock and data activity with the load enable high
    task automatic idle_clock;
        for (int i = 0; i < 8; i++) begin
            serial_gain_in = i[0];
            #160 serial_clk = 1'b1;
            #160 serial_clk = 1'b0;
        end
    endtask
    // Opens and closes a frame with no clock pulses
    task automatic empty_frame;
        #160 load_enable_n = 1'b0;
        #320 load_enable_n = 1'b1;
    endtask
endmodule // sgwl_host_model

// file: sgwl_loader.sv
// Serial gain word loader: sampled three-wire port, gain latch and power controls
module sgwl_loader (
    input  wire logic       clk,              // System clock, 25 MHz
    input  wire logic       sys_rst,          // Synchronous reset, active high
    input  wire logic       serial_clk,       // Serial clock from controller
    input  wire logic       serial_gain_in,   // Serial gain data
    input  wire logic       load_enable_n,    // Load enable, active low
    input  wire logic       transmit_enable,  // High powers up the amplifier unless sleep_n is low
    input  wire logic       sleep_n,          // Low selects sleep
    output logic [6:0]      gain_code,        // Applied gain code
    output logic            gain_valid,       // A load has completed
    output logic            gain_in_range,    // Applied code is 0..71 and a load has completed
    output logic            amp_powered,      // Amplifier transmitting
    output logic            out_high_z        // Output in high impedance
);

    ////////////////////////////////////////////////////////////////////////
    // Types and decoding

    typedef enum logic [1:0] {
        SGWL_IDLE = 2'b01,
        SGWL_LOAD = 2'b10
    } sgwl_frame_e;

    // Whether a seven-bit code lies in the monotonic gain range
    function automatic logic code_in_range(
        input logic [6:0] code
    );
        return code <= sgwl_pkg::CODE_MAX;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every pin

    logic [sgwl_pkg::PIN_N-1:0] pins_raw;
    logic [sgwl_pkg::PIN_N-1:0] pins_sync;

    assign pins_raw[sgwl_pkg::PIN_SCLK]  = serial_clk;
    assign pins_raw[sgwl_pkg::PIN_SERIAL_GAIN_IN] = serial_gain_in;
    assign pins_raw[sgwl_pkg::PIN_LEN_N] = load_enable_n;
    assign pins_raw[sgwl_pkg::PIN_TXEN]  = transmit_enable;
    assign pins_raw[sgwl_pkg::PIN_SLP_N] = sleep_n;

    for (genvar g = 0; g < sgwl_pkg::PIN_N; g++) begin : g_sync
        logic meta_q;
        logic meta_d;
        logic sync_q;
        logic sync_d;

        always_comb begin
            meta_d = pins_raw[g];
            sync_d = meta_q;
        end

        // The first stage may go metastable; only the second is read
        always_ff @(posedge clk) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end

        assign pins_sync[g] = sync_q;
    end

    logic sclk_s;
    logic data_s;
    logic len_n_s;
    logic txen_s;
    logic slp_n_s;

    assign sclk_s  = pins_sync[sgwl_pkg::PIN_SCLK];
    assign data_s  = pins_sync[sgwl_pkg::PIN_SERIAL_GAIN_IN];
    assign len_n_s = pins_sync[sgwl_pkg::PIN_LEN_N];
    assign txen_s  = pins_sync[sgwl_pkg::PIN_TXEN];
    assign slp_n_s = pins_sync[sgwl_pkg::PIN_SLP_N];

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised serial clock and load enable

    logic sclk_prev_q;
    logic sclk_prev_d;
    logic len_prev_q;
    logic len_prev_d;
    logic sclk_rise;
    logic sclk_fall;
    logic len_rise;
    logic len_fall;

    always_comb begin
        sclk_prev_d = sclk_s;
        len_prev_d  = len_n_s;
    end

    // Not reset: the history tracks the pins, so no false edge follows reset
    always_ff @(posedge clk) begin
        sclk_prev_q <= sclk_prev_d;
        len_prev_q  <= len_prev_d;
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign len_rise  = len_n_s & ~len_prev_q;
    assign len_fall  = ~len_n_s & len_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Frame control and master-slave shift register

    sgwl_frame_e state_q;
    sgwl_frame_e state_d;
    logic        armed_q;
    logic        armed_d;
    logic        master_q;
    logic        master_d;
    logic [6:0]  shift_q;
    logic [6:0]  shift_d;

    always_comb begin
        state_d  = state_q;
        armed_d  = armed_q;
        master_d = master_q;
        shift_d  = shift_q;
        case (state_q)
            SGWL_IDLE: begin
                armed_d = 1'b0;
                if (len_fall) begin
                    state_d = SGWL_LOAD;
                end
            end
            SGWL_LOAD: begin
                if (len_n_s) begin
                    state_d = SGWL_IDLE;
                    armed_d = 1'b0;
                end else begin
                    if (sclk_rise) begin
                        master_d = data_s;
                        armed_d  = 1'b1;
                    end
                    // Only a fall that follows a rise inside this frame moves a bit
                    if (sclk_fall && armed_q) begin
                        shift_d = {shift_q[5:0], master_q};
                    end
                end
            end
            default: begin
                state_d = SGWL_IDLE;
                armed_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q  <= SGWL_IDLE;
            armed_q  <= 1'b0;
            master_q <= 1'b0;
            shift_q  <= sgwl_pkg::SHIFT_RST;
        end else begin
            state_q  <= state_d;
            armed_q  <= armed_d;
            master_q <= master_d;
            shift_q  <= shift_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gain latch

    logic [6:0] gain_q;
    logic [6:0] gain_d;
    logic       valid_q;
    logic       valid_d;

    always_comb begin
        gain_d  = gain_q;
        valid_d = valid_q;
        if (len_rise) begin
            gain_d  = shift_q;
            valid_d = 1'b1;
        end
    end

    // The reset value stands in for an unknown gain; gain_valid marks it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_q  <= sgwl_pkg::GAIN_RST;
            valid_q <= 1'b0;
        end else begin
            gain_q  <= gain_d;
            valid_q <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic rng_q;
    logic rng_d;
    logic pwr_q;
    logic pwr_d;
    logic hz_q;
    logic hz_d;

    always_comb begin
        rng_d = valid_d && code_in_range(gain_d);
        pwr_d = txen_s & slp_n_s;
        hz_d  = ~slp_n_s;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rng_q <= 1'b0;
            pwr_q <= 1'b0;
            hz_q  <= 1'b0;
        end else begin
            rng_q <= rng_d;
            pwr_q <= pwr_d;
            hz_q  <= hz_d;
        end
    end

    assign gain_code     = gain_q;
    assign gain_valid    = valid_q;
    assign gain_in_range = rng_q;
    assign amp_powered   = pwr_q;
    assign out_high_z    = hz_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_gain_hold_load: assert property (@(posedge clk) disable iff (sys_rst)
        !len_rise |=> $stable(gain_q))
        else $error("gain changed without load end");

    a_gain_frame_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == SGWL_LOAD && !len_n_s) |=> $stable(gain_q))
        else $error("gain changed while loading");

    a_gain_latch_copy: assert property (@(posedge clk) disable iff (sys_rst)
        len_rise |=> gain_q == $past(shift_q))
        else $error("gain not copied");

    a_load_close: assert property (@(posedge clk) disable iff (sys_rst)
        len_rise |=> gain_valid)
        else $error("load end did not mark gain valid");

    a_shift_idle: assert property (@(posedge clk) disable iff (sys_rst)
        len_n_s |=> $stable(shift_q))
        else $error("shift while disabled");

    a_master_idle: assert property (@(posedge clk) disable iff (sys_rst)
        len_n_s |=> $stable(master_q))
        else $error("capture while disabled");

    a_armed_idle: assert property (@(posedge clk) disable iff (sys_rst)
        len_n_s |=> !armed_q)
        else $error("armed while disabled");

    a_shift_step: assert property (@(posedge clk) disable iff (sys_rst)
        (!len_n_s && sclk_fall && armed_q) |=> shift_q[0] == $past(master_q))
        else $error("bad shift");

    a_shift_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (!len_n_s && sclk_fall && armed_q) |=> shift_q[6:1] == $past(shift_q[5:0]))
        else $error("shifted bits lost");

    a_master_cap: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == SGWL_LOAD && !len_n_s && sclk_rise) |=> master_q == $past(data_s))
        else $error("bad capture");

    a_frame_open: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == SGWL_IDLE && !len_fall) |=> state_q == SGWL_IDLE)
        else $error("frame opened without falling enable");

    a_armed_frame: assert property (@(posedge clk) disable iff (sys_rst)
        armed_q |-> state_q == SGWL_LOAD)
        else $error("armed outside a frame");

    a_state_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot(state_q))
        else $error("frame state not one-hot");

    a_power_level: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> amp_powered == ($past(txen_s) & $past(slp_n_s)))
        else $error("power wrong");

    a_sleep_hiz: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> out_high_z == !$past(slp_n_s))
        else $error("sleep wrong");

    a_hiz_unpowered: assert property (@(posedge clk) disable iff (sys_rst)
        out_high_z |-> !amp_powered)
        else $error("powered while asleep");

    a_range_flag: assert property (@(posedge clk) disable iff (sys_rst)
        gain_valid |-> gain_in_range == code_in_range(gain_code))
        else $error("range wrong");

    a_range_high: assert property (@(posedge clk) disable iff (sys_rst)
        (gain_valid && gain_code > sgwl_pkg::CODE_MAX) |-> !gain_in_range)
        else $error("code above range flagged valid");

    a_range_unloaded: assert property (@(posedge clk) disable iff (sys_rst)
        !gain_valid |-> !gain_in_range)
        else $error("range flagged before a load");

    a_valid_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        gain_valid |=> gain_valid)
        else $error("gain valid dropped");
endmodule // sgwl_loader

// file: sgwl_loader_tb.sv
// Self-checking testbench for the serial gain word loader
module sgwl_loader_tb;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t mismatch", $time); end end
    logic clk = 1'b0, sys_rst = 1'b1, sleep_n = 1'b1, serial_clk, serial_gain_in, load_enable_n;
    logic transmit_enable = 1'b0;
    logic [6:0] gain_code;
    logic gain_valid, gain_in_range, amp_powered, out_high_z;
    int fail_count = 0, check_count = 0;
    always #20 clk = ~clk;
    sgwl_host_model host_u (.serial_clk(serial_clk), .serial_gain_in(serial_gain_in), .load_enable_n(load_enable_n));
    sgwl_loader dut_u (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk), .serial_gain_in(serial_gain_in),
        .load_enable_n(load_enable_n), .transmit_enable(transmit_enable), .sleep_n(sleep_n), .gain_code(gain_code),
        .gain_valid(gain_valid), .gain_in_range(gain_in_range), .amp_powered(amp_powered), .out_high_z(out_high_z));
    task go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task t_load(input logic [7:0] w, input logic [6:0] prev);
        fork
            host_u.load(w);
            begin
                go(30);
                `CHK(gain_code, prev)
            end
        join
        go(6);
        `CHK(gain_code, w[6:0])
        `CHK(gain_in_range, w[6:0] <= sgwl_pkg::CODE_MAX)
        `CHK(gain_valid, 1'b1)
    endtask
    // Clocks with the enable high, then an empty frame applies the untouched shift register
    task t_idle(input logic [6:0] prev);
        host_u.idle_clock();
        host_u.empty_frame();
        go(6);
        `CHK(gain_code, prev)
    endtask
    task t_power;
        for (int i = 0; i < 4; i++) begin
            transmit_enable = i[0];
            sleep_n = i[1];
            go(5);
            `CHK(amp_powered, i[0] & i[1])
            `CHK(out_high_z, !i[1])
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        go(8);
        sys_rst = 1'b0;
        go(3);
        `CHK(gain_valid, 1'b0)
        `CHK(gain_in_range, 1'b0)
        `CHK(amp_powered, 1'b0)
        `CHK(out_high_z, 1'b0)
        t_load(8'h47, 7'h00);
        t_load(8'hC8, 7'h47);
        t_load(8'h80, 7'h48);
        t_load(8'h7F, 7'h00);
        t_idle(7'h7F);
        t_power;
        final_report;
    end
    initial begin
        #200000;
        $display("[ERR] %0t timeout", $time);
        fail_count++;
        final_report;
    end
endmodule // sgwl_loader_tb

// file: sgwl_pkg.sv
// Constants for the serial gain word loader
// Function
// - A falling load enable opens a load; only then are clock pulses accepted.
// - While loading, the applied gain stays unchanged.
// - Bits arrive most significant first, sampled on each rising serial clock.
// - Only the last seven bits are kept; the leading bit falls out.
// - Rising load enable copies the shift register into the gain latch.
// - Codes 0 to 71 are valid; code 71 gives maximum gain.
// - Codes 72 to 127 lie outside the valid range.
// - Codes 128 to 255 act as codes 0 to 127.
// - Low transmit enable powers the amplifier down; high powers it up while the sleep input is high.
// - Low sleep input puts the device asleep with output high impedance.
// - While load enable is high, clock and data are ignored.
// - A bit is captured on the rising clock, passed to slave on falling.
package sgwl_pkg;
    localparam int        GAIN_W     = 7;
    localparam logic [6:0] CODE_MAX  = 7'h47;
    localparam logic [6:0] SHIFT_RST = 7'h00;
    localparam logic [2:0] CNT_RST   = 3'h0;
    localparam logic [6:0] GAIN_RST  = 7'h00;
    localparam int         PIN_SCLK  = 0;
    localparam int         PIN_SERIAL_GAIN_IN = 1;
    localparam int         PIN_LEN_N = 2;
    localparam int         PIN_TXEN  = 3;
    localparam int         PIN_SLP_N = 4;
    localparam int         PIN_N     = 5;
endpackage : sgwl_pkg
